// ---- src/msp_port.sv ----
/*
 * Metering serial port: result latching, record shift-out, command write-in.
 * Assumes measurement records arrive on the clock domain and the host drives
 * the serial clock, which stands high outside frames.
 */
`timescale 1ns/1ns
`default_nettype none
module msp_port
  import msp_pkg::*;
#(
  parameter int REC_COUNT = REC_N
) (
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  input  wire logic                           serial_bit_clock,
  input  wire logic                           port_select_n,
  input  wire logic                           latch_dir_strobe,
  input  wire logic                           serial_data_line,
  input  wire logic [REC_COUNT-1:0][REC_W-1:0] meas_records,
  input  wire logic                           bit_order_select,
  input  wire logic                           standalone_mode,
  input  wire logic [2:0]                     meter_status,
  output var  logic                           serial_data_out,
  output var  logic                           serial_data_oe,
  output var  logic                           strobe_out,
  output var  logic                           strobe_oe,
  output var  logic                           serial_bit_clock_out,
  output var  logic                           serial_bit_clock_oe,
  output var  logic [MODE_N-1:0]              mode_bits,
  output var  logic                           records_swapped,
  output var  logic                           cfg_write_pulse,
  output var  logic [ADDR_W-1:0]              cfg_write_addr,
  output var  logic                           cfg_write_value,
  output var  logic                           remote_reset_pulse
);

  localparam int CNT_W = $clog2(REC_COUNT * REC_W);
  localparam int SYN_W = 3 + CNT_W + 1;
  // Pins idle high, counter and toggle idle low
  localparam logic [SYN_W-1:0] SYN_IDLE = {3'b111, {(CNT_W + 1){1'b0}}};

  initial begin
    if (REC_COUNT != 2 && REC_COUNT != 4 && REC_COUNT != 8) begin
      $error("REC_COUNT must be 2, 4 or 8");
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // Parity nibble: bitwise xor of the seven data nibbles
  function automatic logic [REC_W-1:0] add_parity(input logic [REC_W-1:0] d);
    logic [NIBBLE_W-1:0] p;
    logic [REC_W-1:0]    r;
    p = '0;
    for (int n = 0; n < PARITY_LSB / NIBBLE_W; n++) begin
      p = p ^ d[n*NIBBLE_W +: NIBBLE_W];
    end
    r = d;
    r[PARITY_LSB +: NIBBLE_W] = p;
    return r;
  endfunction : add_parity

  // ****************************************
  // Link domain: read bit counter (trailing edge)
  // ****************************************
  logic             rd_run_n_reg;
  logic             wr_run_n_reg;
  logic [CNT_W-1:0] rd_bin_reg;
  logic [CNT_W-1:0] rd_bin_next;
  logic [CNT_W-1:0] rd_gray_reg;
  logic [CNT_W-1:0] rd_gray_next;

  // Counter advances by one, so its gray form crosses safely; wraps after REC_COUNT * REC_W bits
  always_comb begin
    rd_bin_next  = rd_bin_reg + 1'b1;
    rd_gray_next = rd_bin_next ^ (rd_bin_next >> 1);
  end

  // Held clear while not reading, so a strobe pulse rezeroes it
  always_ff @(posedge serial_bit_clock or negedge rd_run_n_reg) begin
    if (!rd_run_n_reg) begin
      rd_bin_reg  <= '0;
      rd_gray_reg <= '0;
    end else begin
      rd_bin_reg  <= rd_bin_next;
      rd_gray_reg <= rd_gray_next;
    end
  end

  // ****************************************
  // Link domain: command shifter (leading edge)
  // ****************************************
  logic [2:0]          wr_cnt_reg;
  logic [2:0]          wr_cnt_next;
  logic [CMD_BITS-2:0] wr_shift_reg;
  logic [CMD_BITS-2:0] wr_shift_next;
  msp_cmd_t            cmd_hold_reg;
  msp_cmd_t            cmd_hold_next;
  logic                cmd_tog_reg;
  logic                cmd_tog_next;

  always_comb begin
    wr_cnt_next   = wr_cnt_reg + 3'h1;
    wr_shift_next = {wr_shift_reg[CMD_BITS-3:0], serial_data_line};
    cmd_hold_next = cmd_hold_reg;
    cmd_tog_next  = cmd_tog_reg;
    if (wr_cnt_reg == 3'h7) begin
      // Execute bit is ignored; its own clock edge commits the command
      cmd_hold_next = msp_cmd_t'(wr_shift_reg);
      cmd_tog_next  = ~cmd_tog_reg;
    end
  end

  always_ff @(negedge serial_bit_clock or negedge wr_run_n_reg) begin
    if (!wr_run_n_reg) begin
      wr_cnt_reg   <= '0;
      wr_shift_reg <= '0;
    end else begin
      wr_cnt_reg   <= wr_cnt_next;
      wr_shift_reg <= wr_shift_next;
    end
  end

  // Kept out of the frame reset so that clearing never fakes an event
  always_ff @(negedge serial_bit_clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_hold_reg <= '0;
      cmd_tog_reg  <= 1'b0;
    end else if (wr_run_n_reg) begin
      cmd_hold_reg <= cmd_hold_next;
      cmd_tog_reg  <= cmd_tog_next;
    end
  end

  // ****************************************
  // Crossing into the measurement clock
  // ****************************************
  logic [SYN_W-1:0] syn_in;
  logic [SYN_W-1:0] syn_out;
  msp_pins_t        pins;
  logic [CNT_W-1:0] rd_gray_s;
  logic             cmd_tog_s;

  assign syn_in = {port_select_n, latch_dir_strobe, serial_bit_clock, rd_gray_reg,
                   cmd_tog_reg};

  msp_sync #(.WIDTH(SYN_W), .RESET_VAL(SYN_IDLE)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (syn_in),
    .sync_out (syn_out)
  );

  assign pins      = msp_pins_t'(syn_out[SYN_W-1 -: 3]);
  assign rd_gray_s = syn_out[CNT_W:1];
  assign cmd_tog_s = syn_out[0];

  // ****************************************
  // Measurement domain: latching and reset
  // ****************************************
  msp_lat_state_t            lat_state_reg;
  msp_lat_state_t            lat_state_next;
  logic [CNT_SAT_W-1:0]      lat_cnt_reg;
  logic [CNT_SAT_W-1:0]      lat_cnt_next;
  logic [CNT_SAT_W-1:0]      rrr_cnt_reg;
  logic [CNT_SAT_W-1:0]      rrr_cnt_next;
  logic                      rrr_next;
  logic                      latch_now;
  logic [REC_W-1:0]          snap_reg [REC_COUNT];
  logic [REC_W-1:0]          snap_next [REC_COUNT];
  logic                      sel_idle;

  assign sel_idle = pins.sel_n;

  always_comb begin
    lat_state_next = lat_state_reg;
    lat_cnt_next   = lat_cnt_reg;
    latch_now      = 1'b0;
    rrr_cnt_next   = '0;
    rrr_next       = 1'b0;
    // Clock low with select and strobe idle requests a remote reset
    if (sel_idle && pins.strobe && !pins.sclk) begin
      // Counts one past the threshold and parks, so the pulse fires once
      rrr_cnt_next = (rrr_cnt_reg > CNT_SAT_W'(RRR_MIN_CYC)) ? rrr_cnt_reg
                                                               : rrr_cnt_reg + 1'b1;
      rrr_next     = (rrr_cnt_reg == CNT_SAT_W'(RRR_MIN_CYC));
    end
    unique case (lat_state_reg)
      LAT_WAIT: begin
        lat_cnt_next = '0;
        if (sel_idle && !pins.strobe) begin
          lat_state_next = LAT_LOW;
          lat_cnt_next   = CNT_SAT_W'(1);
        end
      end
      LAT_LOW: begin
        if (pins.strobe) begin
          // Latch pulse too short to count: drop it
          lat_state_next = (lat_cnt_reg >= CNT_SAT_W'(LATCH_MIN_CYC)) ? LAT_HIGH : LAT_WAIT;
          lat_cnt_next   = CNT_SAT_W'(1);
        end else if (lat_cnt_reg < CNT_SAT_W'(LATCH_MIN_CYC)) begin
          lat_cnt_next = lat_cnt_reg + 1'b1;
        end
      end
      LAT_HIGH: begin
        if (!pins.strobe) begin
          lat_state_next = LAT_WAIT;
        end else if (lat_cnt_reg == CNT_SAT_W'(LATCH_MIN_CYC - 1)) begin
          latch_now      = 1'b1;
          lat_state_next = LAT_WAIT;
        end else begin
          lat_cnt_next = lat_cnt_reg + 1'b1;
        end
      end
    endcase
    for (int r = 0; r < REC_COUNT; r++) begin
      snap_next[r] = latch_now ? add_parity(meas_records[r]) : snap_reg[r];
    end
    if (rrr_next) begin
      lat_state_next = LAT_WAIT;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lat_state_reg      <= LAT_WAIT;
      lat_cnt_reg        <= '0;
      rrr_cnt_reg        <= '0;
      remote_reset_pulse <= 1'b0;
      for (int r = 0; r < REC_COUNT; r++) begin
        snap_reg[r] <= '0;
      end
    end else begin
      lat_state_reg      <= lat_state_next;
      lat_cnt_reg        <= lat_cnt_next;
      rrr_cnt_reg        <= rrr_cnt_next;
      remote_reset_pulse <= rrr_next;
      for (int r = 0; r < REC_COUNT; r++) begin
        snap_reg[r] <= snap_next[r];
      end
    end
  end

  // ****************************************
  // Measurement domain: pins and shift-out
  // ****************************************
  logic             rd_run_n_next;
  logic             wr_run_n_next;
  logic [CNT_W-1:0] bit_idx;
  logic [CNT_W-REC_LSB-1:0] rec_sel;
  logic [BIT_SEL_W-1:0]     bit_sel;
  logic             sdo_next;
  logic             sdo_oe_next;
  logic             stb_oe_next;
  logic             clk_oe_next;

  always_comb begin
    rd_run_n_next = !sel_idle && pins.strobe;
    wr_run_n_next = !sel_idle && !pins.strobe;
    bit_idx       = gray2bin(rd_gray_s);
    rec_sel       = bit_idx[CNT_W-1:REC_LSB];
    if (records_swapped) begin
      rec_sel[CNT_W-REC_LSB-1] = ~rec_sel[CNT_W-REC_LSB-1];
    end
    bit_sel = bit_order_select ? bit_idx[BIT_SEL_W-1:0]
                               : ~bit_idx[BIT_SEL_W-1:0];
    // Byte index grows from the least significant byte
    sdo_next    = snap_reg[rec_sel][{bit_idx[REC_LSB-1:BYTE_LSB], bit_sel}];
    sdo_oe_next = rd_run_n_next;
    stb_oe_next = 1'b0;
    clk_oe_next = 1'b0;
    // Status shows only while the host leaves select idle
    if (sel_idle && standalone_mode) begin
      sdo_next    = meter_status[0];
      sdo_oe_next = 1'b1;
      stb_oe_next = 1'b1;
      clk_oe_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_run_n_reg         <= 1'b0;
      wr_run_n_reg         <= 1'b0;
      serial_data_out      <= 1'b1;
      serial_data_oe       <= 1'b0;
      strobe_out           <= 1'b1;
      strobe_oe            <= 1'b0;
      serial_bit_clock_out <= 1'b1;
      serial_bit_clock_oe  <= 1'b0;
    end else begin
      rd_run_n_reg         <= rd_run_n_next;
      wr_run_n_reg         <= wr_run_n_next;
      serial_data_out      <= sdo_next;
      serial_data_oe       <= sdo_oe_next;
      strobe_out           <= meter_status[1];
      strobe_oe            <= stb_oe_next;
      serial_bit_clock_out <= meter_status[2];
      serial_bit_clock_oe  <= clk_oe_next;
    end
  end

  // ****************************************
  // Measurement domain: command execution
  // ****************************************
  logic                tog_seen_reg;
  logic                read_seen_reg;
  logic                read_seen_next;
  logic [MODE_N-1:0]   mode_next;
  logic                swap_next;
  logic                cfg_pulse_next;
  logic [ADDR_W-1:0]   cfg_addr_next;
  logic                cfg_value_next;
  logic                cmd_event;

  always_comb begin
    cmd_event      = (cmd_tog_s != tog_seen_reg);
    mode_next      = mode_bits;
    swap_next      = records_swapped;
    read_seen_next = read_seen_reg || rd_run_n_next;
    cfg_pulse_next = 1'b0;
    cfg_addr_next  = cfg_write_addr;
    cfg_value_next = cfg_write_value;
    // Swap is single use: dropped once a frame that read closes
    if (sel_idle && read_seen_reg) begin
      swap_next      = 1'b0;
      read_seen_next = 1'b0;
    end
    // Held word is stable: next command needs eight more serial clocks
    if (cmd_event) begin
      if (cmd_hold_reg.addr >= MODE_BASE) begin
        mode_next[cmd_hold_reg.addr[2:0]] = cmd_hold_reg.value;
        if (cmd_hold_reg.addr[2:0] == MODE_SWAP) begin
          swap_next = cmd_hold_reg.value;
        end
      end else begin
        cfg_pulse_next = 1'b1;
        cfg_addr_next  = cmd_hold_reg.addr;
        cfg_value_next = cmd_hold_reg.value;
      end
    end
  end

  // Mode bits clear only on reset_n; the remote reset leaves them alone
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tog_seen_reg    <= 1'b0;
      read_seen_reg   <= 1'b0;
      mode_bits       <= '0;
      records_swapped <= 1'b0;
      cfg_write_pulse <= 1'b0;
      cfg_write_addr  <= '0;
      cfg_write_value <= 1'b0;
    end else begin
      tog_seen_reg    <= cmd_tog_s;
      read_seen_reg   <= read_seen_next;
      mode_bits       <= mode_next;
      records_swapped <= swap_next;
      cfg_write_pulse <= cfg_pulse_next;
      cfg_write_addr  <= cfg_addr_next;
      cfg_write_value <= cfg_value_next;
    end
  end

endmodule : msp_port
`default_nettype wire

// ---- src/msp_pkg.sv ----
/*
 * Constants, carrier types and state encodings for the metering serial port.
 * Assumes a measurement clock of CLK_PERIOD_NS and a serial clock from the host.
 */
package msp_pkg;

  // ****************************************
  // Record geometry
  // ****************************************
  localparam int REC_W       = 32;
  localparam int REC_N       = 8;
  localparam int BIT_SEL_W   = 3;
  localparam int BYTE_LSB    = 3;
  localparam int REC_LSB     = 5;
  localparam int NIBBLE_W    = 4;
  localparam int PARITY_LSB  = 28;

  // ****************************************
  // Command decode
  // ****************************************
  localparam int          CMD_BITS     = 8;
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  MODE_BASE    = 6'h38;
  localparam logic [2:0]  MODE_SWAP    = 3'h7;
  localparam int          MODE_N       = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RRR_MIN_NS      = 30;
  localparam int RRR_MIN_CYC     = (RRR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_MIN_CYC   = 2;
  localparam int CNT_SAT_W       = 3;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic sel_n;
    logic strobe;
    logic sclk;
  } msp_pins_t;

  typedef struct packed {
    logic             value;
    logic [ADDR_W-1:0] addr;
  } msp_cmd_t;

  typedef enum logic [1:0] {
    LAT_WAIT,
    LAT_LOW,
    LAT_HIGH
  } msp_lat_state_t;

endpackage : msp_pkg

// ---- src/msp_sync.sv ----
/*
 * Two flip-flop synchroniser, one stage pair per bit.
 * Assumes each bit is a level or a gray-coded word that moves one bit at a time.
 */
`timescale 1ns/1ns
`default_nettype none
module msp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ****************************************
  // Per-bit stages
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          // Reset to the idle level so release never fakes activity
          meta_reg[gi] <= RESET_VAL[gi];
          sync_out[gi] <= RESET_VAL[gi];
        end else begin
          meta_reg[gi] <= async_in[gi];
          sync_out[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

endmodule : msp_sync
`default_nettype wire

// ---- dv/msp_port_chk.sv ----
/* Concurrent checks on the pin drivers and decoded outputs of msp_port.
   Assumes host pins change slowly against the 100 MHz measurement clock. */
`timescale 1ns/1ns
`default_nettype none
module msp_port_chk
  import msp_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              serial_bit_clock,
  input wire logic              port_select_n,
  input wire logic              latch_dir_strobe,
  input wire logic              standalone_mode,
  input wire logic [2:0]        meter_status,
  input wire logic              serial_data_oe,
  input wire logic              strobe_out,
  input wire logic              strobe_oe,
  input wire logic              serial_bit_clock_out,
  input wire logic              serial_bit_clock_oe,
  input wire logic [MODE_N-1:0] mode_bits,
  input wire logic              cfg_write_pulse,
  input wire logic [ADDR_W-1:0] cfg_write_addr,
  input wire logic              remote_reset_pulse
);
  // ****
  // Properties
  // ****
  // Repeat counts leave room for the two-stage pin synchronisers
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  AST_IDLE_RELEASE: assert property (
    (port_select_n && !standalone_mode) [*6] |-> !serial_data_oe)
    else $error("data pin driven while port idle");
  AST_WRITE_LISTEN: assert property (
    (!port_select_n && !latch_dir_strobe) [*6] |-> !serial_data_oe)
    else $error("data pin driven in write mode");
  AST_READ_DRIVE: assert property (
    (!port_select_n && latch_dir_strobe) [*6] |-> serial_data_oe)
    else $error("data pin not driven in read mode");
  AST_SELECT_STATUS: assert property (
    (!port_select_n) [*4] |-> !strobe_oe && !serial_bit_clock_oe)
    else $error("status drive while selected");
  AST_STANDALONE: assert property (
    (standalone_mode && port_select_n && $stable(meter_status)) [*5] |->
      strobe_oe && strobe_out == meter_status[1] && serial_bit_clock_out == meter_status[2])
    else $error("status pins wrong in standalone");
  AST_WRITE_PULSE: assert property (
    cfg_write_pulse |=> !cfg_write_pulse)
    else $error("config write pulse too long");
  AST_WRITE_DECODE: assert property (
    cfg_write_pulse |-> !$past(latch_dir_strobe, 3) ##1 cfg_write_addr < MODE_BASE)
    else $error("config write outside write mode or range");
  AST_RRESET_CAUSE: assert property (
    remote_reset_pulse |-> port_select_n && !$past(serial_bit_clock, 3))
    else $error("remote reset without request");
  AST_RRESET_MODES: assert property (
    remote_reset_pulse |=> $stable(mode_bits) [*3])
    else $error("mode bits disturbed by remote reset");
  COV_WRITE: cover property (cfg_write_pulse);
  COV_RRESET: cover property (remote_reset_pulse);
  COV_READ: cover property (serial_data_oe && !port_select_n);
endmodule : msp_port_chk

bind msp_port msp_port_chk msp_port_chk_inst (
  .clock(clock), .reset_n(reset_n), .serial_bit_clock(serial_bit_clock),
  .port_select_n(port_select_n), .latch_dir_strobe(latch_dir_strobe),
  .standalone_mode(standalone_mode), .meter_status(meter_status),
  .serial_data_oe(serial_data_oe), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
  .serial_bit_clock_out(serial_bit_clock_out), .serial_bit_clock_oe(serial_bit_clock_oe),
  .mode_bits(mode_bits), .cfg_write_pulse(cfg_write_pulse),
  .cfg_write_addr(cfg_write_addr), .remote_reset_pulse(remote_reset_pulse));
`default_nettype wire

// ---- dv/msp_host.sv ----
/* Host master model for the metering serial port link.
   Assumes a 125 ns serial clock period and a weak pull-up on the data pin. */
`timescale 1ns/1ns
`default_nettype none
module msp_host (
  output var  logic port_select_n,
  output var  logic latch_dir_strobe,
  output var  logic serial_bit_clock,
  output wire logic serial_data_line,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe
);
  logic drv_en;
  logic drv_val;
  // Released line floats to the pull-up level
  assign serial_data_line = serial_data_oe ? serial_data_out : drv_en ? drv_val : 1'b1;
  initial begin
    port_select_n = 1'b1;
    latch_dir_strobe = 1'b1;
    serial_bit_clock = 1'b1;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  // ****
  // Link tasks
  // ****
  task automatic go_idle;
    port_select_n = 1'b1;
    latch_dir_strobe = 1'b1;
    serial_bit_clock = 1'b1;
    drv_en = 1'b0;
    #100;
  endtask : go_idle
  task automatic latch_results;
    latch_dir_strobe = 1'b0;
    #100;
    latch_dir_strobe = 1'b1;
    #100;
  endtask : latch_results
  task automatic remote_reset;
    serial_bit_clock = 1'b0;
    #80;
    serial_bit_clock = 1'b1;
    #100;
  endtask : remote_reset
  // Shifts only, never relatches, so a repeat read sees the same data
  task automatic begin_read;
    port_select_n = 1'b0;
    #50;
    latch_dir_strobe = 1'b0;
    #50;
    latch_dir_strobe = 1'b1;
    #100;
  endtask : begin_read
  task automatic shift_bit(input logic d, output logic q);
    drv_val = d;
    #62;
    serial_bit_clock = 1'b0;
    q = serial_data_line;
    #63;
    serial_bit_clock = 1'b1;
  endtask : shift_bit
  task automatic read_bits(input int n, output logic [255:0] q);
    q = '1;
    for (int i = 0; i < n; i++) shift_bit(1'b1, q[i]);
  endtask : read_bits
  task automatic write_cmd(input logic v, input logic [5:0] a);
    logic [7:0] cmd;
    logic q;
    cmd = {v, a, 1'b1};
    port_select_n = 1'b0;
    latch_dir_strobe = 1'b0;
    #100;
    drv_en = 1'b1;
    for (int i = 7; i >= 0; i--) shift_bit(cmd[i], q);
    #100;
    go_idle();
  endtask : write_cmd
endmodule : msp_host
`default_nettype wire

// ---- dv/testbench.sv ----
/* Self-checking bench for msp_port driven by the msp_host link model.
   Assumes the host model owns all link pin timing. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic             clock;
  logic             reset_n;
  logic [7:0][31:0] recs;
  logic [7:0][31:0] snap;
  logic             bit_order_select;
  logic             standalone_mode;
  logic [2:0]       meter_status;
  logic             sel_n, strobe, sbc, sd_out, sd_oe, st_out, st_oe, sc_out, sc_oe;
  wire  logic       sdl;
  logic [7:0]       mode_bits;
  logic [5:0]       cfg_a;
  logic             swapped, cfg_p, cfg_v, rr_p;
  int               fail_count = 0, n_checks = 0, cycles = 0, cfg_cnt = 0, rr_cnt = 0;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  msp_host msp_host_inst (.port_select_n(sel_n), .latch_dir_strobe(strobe),
    .serial_bit_clock(sbc), .serial_data_line(sdl), .serial_data_out(sd_out),
    .serial_data_oe(sd_oe));

  msp_port #(.REC_COUNT(8)) msp_port_inst (.clock(clock), .reset_n(reset_n),
    .serial_bit_clock(sbc), .port_select_n(sel_n), .latch_dir_strobe(strobe),
    .serial_data_line(sdl), .meas_records(recs), .bit_order_select(bit_order_select),
    .standalone_mode(standalone_mode), .meter_status(meter_status),
    .serial_data_out(sd_out), .serial_data_oe(sd_oe), .strobe_out(st_out),
    .strobe_oe(st_oe), .serial_bit_clock_out(sc_out), .serial_bit_clock_oe(sc_oe),
    .mode_bits(mode_bits), .records_swapped(swapped), .cfg_write_pulse(cfg_p),
    .cfg_write_addr(cfg_a), .cfg_write_value(cfg_v), .remote_reset_pulse(rr_p));

  // ****
  // Checking and closing
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  always @(negedge clock) begin
    cycles++;
    if (cfg_p === 1'b1) cfg_cnt++;
    if (rr_p === 1'b1) rr_cnt++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end

  // ****
  // Expected read stream
  // ****
  function automatic logic exp_bit(input int b, input logic sw, input logic ord);
    logic [31:0] r;
    int          k;
    r = snap[((b / 32) % 8) ^ (sw ? 4 : 0)];
    r[31:28] = 4'h0;
    for (int i = 0; i < 7; i++) r[31:28] ^= r[4 * i +: 4];
    k = (b % 32) / 8 * 8 + (ord ? b % 8 : 7 - b % 8);
    return r[k];
  endfunction : exp_bit
  task automatic read_cmp(input int n, input logic sw, input logic ord);
    logic [255:0] got;
    msp_host_inst.begin_read();
    msp_host_inst.read_bits(n, got);
    for (int b = 0; b < n; b++) check("read_bit", got[b], exp_bit(b, sw, ord));
  endtask : read_cmp

  // ****
  // Scenarios
  // ****
  task automatic t_reset_state;
    check("pin_oe", {sd_oe, st_oe, sc_oe}, 3'b000);
    check("pin_out", {sd_out, st_out, sc_out},
          {exp_bit(0, 1'b0, 1'b0), meter_status[1], meter_status[2]});
    check("outs", {mode_bits, swapped, cfg_p, rr_p}, 0);
  endtask : t_reset_state
  task automatic t_read_all;
    @(negedge clock);
    foreach (recs[i]) recs[i] = 32'(32'h9e37_79b9 * (i + 1));
    snap = recs;
    msp_host_inst.latch_results();
    read_cmp(256, 1'b0, 1'b0);
    msp_host_inst.go_idle();
  endtask : t_read_all
  task automatic t_reshift;
    @(negedge clock);
    recs = ~recs;
    bit_order_select = 1'b1;
    read_cmp(40, 1'b0, 1'b1);
    read_cmp(12, 1'b0, 1'b1);
    msp_host_inst.go_idle();
    check("abort_oe", sd_oe, 0);
    @(negedge clock);
    bit_order_select = 1'b0;
  endtask : t_reshift
  task automatic t_write;
    int base;
    base = cfg_cnt;
    msp_host_inst.write_cmd(1'b0, 6'h2f);
    check("cfg_pulses", cfg_cnt - base, 1);
    check("cfg_write", {cfg_a, cfg_v}, {6'h2f, 1'b0});
    msp_host_inst.write_cmd(1'b1, 6'h05);
    check("cfg_write", {cfg_a, cfg_v}, {6'h05, 1'b1});
    for (int n = 0; n < 7; n++) msp_host_inst.write_cmd(1'b1, 6'(6'h38 + n));
    check("mode_bits", mode_bits[6:0], 7'h7f);
    check("cfg_pulses", cfg_cnt - base, 2);
    msp_host_inst.write_cmd(1'b1, 6'h3f);
    check("swapped", swapped, 1);
    read_cmp(64, 1'b1, 1'b0);
    msp_host_inst.go_idle();
    check("swapped", swapped, 0);
  endtask : t_write
  task automatic t_remote_reset;
    int base;
    base = rr_cnt;
    msp_host_inst.remote_reset();
    check("rr_pulses", rr_cnt - base, 1);
    check("mode_bits", mode_bits[6:0], 7'h7f);
    msp_host_inst.write_cmd(1'b0, 6'h38);
    check("mode_bits", mode_bits[6:0], 7'h7e);
  endtask : t_remote_reset
  task automatic t_standalone;
    @(negedge clock);
    standalone_mode = 1'b1;
    // Status matches host idle levels so the shared pins never fight
    meter_status = 3'b110;
    repeat (8) @(negedge clock);
    check("status_pins", {st_oe, sc_oe, st_out, sc_out}, 4'hf);
    check("data_pin", {sd_oe, sd_out}, 2'b10);
    msp_host_inst.begin_read();
    check("status_oe", {sc_oe, st_oe}, 0);
    msp_host_inst.go_idle();
    @(negedge clock);
    standalone_mode = 1'b0;
  endtask : t_standalone

  initial begin
    reset_n = 1'b0;
    recs = '0;
    snap = '0;
    bit_order_select = 1'b0;
    standalone_mode = 1'b0;
    meter_status = 3'b000;
    repeat (5) @(negedge clock);
    check("rst_pins", {sd_oe, st_oe, sc_oe, sd_out, st_out, sc_out}, 6'h07);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_reset_state();
    t_read_all();
    t_reshift();
    t_write();
    t_remote_reset();
    t_standalone();
    test_done();
  end
endmodule : testbench
`default_nettype wire
